// >>> rtl/tbx_exec.sv
// Purpose: executes byte-table and halfword-table branches, gates fpu instructions
// Assumes: decoder presents one instruction per START pulse, memory acks later
// Notes:   one branch in flight; START is ignored while BUSY is high
//          fault causes hold until the next fault, the pulse lasts as long as the fault condition holds
`timescale 1ns/1ps
`default_nettype none
module tbx_exec (
    input  wire logic                         CLK_IN,
    input  wire logic                         ARST_N_IN,
    input  wire logic                         START_IN,
    input  wire logic                         HALF_IN,
    input  wire logic [tbx_pkg::ADDR_W-1:0]   INSN_ADDR_IN,
    input  wire logic [tbx_pkg::REG_W-1:0]    BASE_SEL_IN,
    input  wire logic [tbx_pkg::REG_W-1:0]    INDEX_SEL_IN,
    input  wire logic [tbx_pkg::ADDR_W-1:0]   BASE_VAL_IN,
    input  wire logic [tbx_pkg::ADDR_W-1:0]   INDEX_VAL_IN,
    input  wire logic                         IN_IT_BLOCK_IN,
    input  wire logic                         IT_LAST_IN,
    input  wire logic                         FP_INSN_IN,
    input  wire logic                         FPU_PRESENT_IN,
    input  wire logic                         FPU_ENABLE_IN,
    output logic                              FP_ACCEPT_OUT,
    output logic                              FP_REJECT_OUT,
    output logic                              MEM_REQ_OUT,
    output logic [tbx_pkg::ADDR_W-1:0]        MEM_ADDR_OUT,
    output logic                              MEM_HALF_OUT,
    input  wire logic                         MEM_ACK_IN,
    input  wire logic [15:0]                  MEM_RDATA_IN,
    output logic                              BUSY_OUT,
    output logic                              REDIRECT_OUT,
    output logic [tbx_pkg::ADDR_W-1:0]        TARGET_OUT,
    output logic                              FAULT_OUT,
    output tbx_pkg::tbx_fault_t               FAULT_CODE_OUT
);
    import tbx_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_REQ,
        ST_WAIT
    } tbx_state_t;

    tbx_mem_if mif ();

    tbx_state_t        state_r;
    logic [ADDR_W-1:0] next_pc_r;
    logic [ADDR_W-1:0] tab_addr_r;
    logic              half_r;
    logic              pin_fpp_s1_r;
    logic              pin_fpp_r;
    logic              pin_fpe_s1_r;
    logic              pin_fpe_r;
    logic [ADDR_W-1:0] next_pc;
    logic [ADDR_W-1:0] base_eff;
    logic [ADDR_W-1:0] index_eff;
    logic              bad_reg;
    logic              bad_it;

    // decoded strobes shared by several processes
    logic              take_start;
    logic              entry_done;
    logic              fpu_ok;
    logic              fault_any;
    tbx_fault_t        fault_kind;

    function automatic logic [ADDR_W-1:0] entry_offset(input logic [15:0] entry);
        // unsigned entry doubled keeps the target halfword aligned
        entry_offset = {15'h0000, entry, 1'b0};
    endfunction : entry_offset

    assign next_pc   = INSN_ADDR_IN + INSN_LEN;
    assign base_eff  = (BASE_SEL_IN == REG_PC) ? next_pc : BASE_VAL_IN;
    assign index_eff = HALF_IN ? {INDEX_VAL_IN[ADDR_W-2:0], 1'b0} : INDEX_VAL_IN;
    // illegal operands are caught rather than trusted, so a bad table walk never issues
    assign bad_reg   = (BASE_SEL_IN == REG_SP) || (INDEX_SEL_IN == REG_SP)
                     || (INDEX_SEL_IN == REG_PC);
    assign bad_it    = IN_IT_BLOCK_IN && !IT_LAST_IN;

    // fpu straps may come from another domain, so they are synchronised
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            pin_fpp_s1_r <= 1'b0;
            pin_fpp_r    <= 1'b0;
            pin_fpe_s1_r <= 1'b0;
            pin_fpe_r    <= 1'b0;
        end else begin
            pin_fpp_s1_r <= FPU_PRESENT_IN;
            pin_fpp_r    <= pin_fpp_s1_r;
            pin_fpe_s1_r <= FPU_ENABLE_IN;
            pin_fpe_r    <= pin_fpe_s1_r;
        end
    end

    // straps are read only behind both sync stages; a half-set pair reads as no fpu
    assign fpu_ok        = pin_fpp_r && pin_fpe_r;
    assign FP_ACCEPT_OUT = FP_INSN_IN && fpu_ok;
    assign FP_REJECT_OUT = FP_INSN_IN && !fpu_ok;

    // a start is looked at only in idle; one held into the busy cycles is dropped
    assign take_start = (state_r == ST_IDLE) && START_IN && !bad_reg && !bad_it;
    assign entry_done = (state_r == ST_WAIT) && mif.rsp_valid;

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (take_start) begin
                        state_r <= ST_REQ;
                    end
                end
                ST_REQ: begin
                    // the port takes one read at a time; ready drops while it is out
                    if (mif.req_ready) begin
                        state_r <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    // entry and valid arrive together, one cycle after the ack
                    if (entry_done) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // operands are frozen at the start so the decoder may move on during the read
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            next_pc_r  <= ADDR_RESET;
            tab_addr_r <= ADDR_RESET;
            half_r     <= 1'b0;
        end else if (take_start) begin
            next_pc_r  <= next_pc;
            tab_addr_r <= base_eff + index_eff;
            half_r     <= HALF_IN;
        end
    end

    assign mif.req_valid = (state_r == ST_REQ);
    assign mif.req_addr  = tab_addr_r;
    assign mif.req_half  = half_r;
    assign BUSY_OUT      = (state_r != ST_IDLE);

    // redirect only after the entry returns, never speculatively
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            REDIRECT_OUT <= 1'b0;
        end else begin
            REDIRECT_OUT <= entry_done;
        end
    end

    // target holds between branches, so a slow fetch unit may still pick it up
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            TARGET_OUT <= ADDR_RESET;
        end else if (entry_done) begin
            TARGET_OUT <= next_pc_r + entry_offset(mif.rsp_data);
        end
    end

    // fpu refusal outranks operand faults; it needs no table state
    always_comb begin
        fault_any  = 1'b1;
        fault_kind = TBX_OK;
        if (FP_INSN_IN && !fpu_ok) begin
            fault_kind = TBX_NO_FPU;
        end else if ((state_r == ST_IDLE) && START_IN && bad_reg) begin
            fault_kind = TBX_BAD_REG;
        end else if ((state_r == ST_IDLE) && START_IN && bad_it) begin
            fault_kind = TBX_BAD_IT;
        end else begin
            fault_any = 1'b0;
        end
    end

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            FAULT_OUT <= 1'b0;
        end else begin
            FAULT_OUT <= fault_any;
        end
    end

    // the cause holds after the pulse so it can be read late
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            FAULT_CODE_OUT <= TBX_OK;
        end else if (fault_any) begin
            FAULT_CODE_OUT <= fault_kind;
        end
    end

    // the port owns the memory pins, so the sequencer never sees a half-registered request
    tbx_mem_port u_port (
        .clk       (CLK_IN),
        .arst_n    (ARST_N_IN),
        .mif       (mif),
        .mem_req   (MEM_REQ_OUT),
        .mem_addr  (MEM_ADDR_OUT),
        .mem_half  (MEM_HALF_OUT),
        .mem_ack   (MEM_ACK_IN),
        .mem_rdata (MEM_RDATA_IN)
    );
endmodule : tbx_exec
`default_nettype wire

// >>> rtl/tbx_pkg.sv
// Purpose: shared constants and types for the table branch execution block
// Assumes: 32-bit addresses, 16-bit instruction halfwords
// Notes:   register numbers follow the usual core numbering
package tbx_pkg;
    localparam int          ADDR_W        = 32;
    localparam int          REG_W         = 4;
    localparam logic [3:0]  REG_SP        = 4'hd;
    localparam logic [3:0]  REG_PC        = 4'hf;
    localparam logic [31:0] INSN_LEN      = 32'h0000_0004;
    localparam logic [31:0] ADDR_RESET    = 32'h0000_0000;
    localparam logic [15:0] ENTRY_RESET   = 16'h0000;

    typedef enum logic [1:0] {
        TBX_OK,
        TBX_BAD_REG,
        TBX_BAD_IT,
        TBX_NO_FPU
    } tbx_fault_t;
endpackage : tbx_pkg

// >>> rtl/tbx_mem_if.sv
// Purpose: table entry read channel between the sequencer and the fetch port
// Assumes: one outstanding read at a time
// Notes:   valid/ready handshake on request, valid only on response
`timescale 1ns/1ps
`default_nettype none
interface tbx_mem_if;
    import tbx_pkg::*;
    logic              req_valid;
    logic              req_ready;
    logic [ADDR_W-1:0] req_addr;
    logic              req_half;
    logic              rsp_valid;
    logic [15:0]       rsp_data;

    modport seq  (output req_valid, req_addr, req_half, input req_ready, rsp_valid, rsp_data);
    modport port (input req_valid, req_addr, req_half, output req_ready, rsp_valid, rsp_data);
endinterface : tbx_mem_if
`default_nettype wire

// >>> rtl/tbx_mem_port.sv
// Purpose: registers the table fetch onto the memory pins and extracts the entry
// Assumes: memory answers with a one-cycle valid pulse, data in low bits
// Notes:   byte entries are zero extended here
`timescale 1ns/1ps
`default_nettype none
module tbx_mem_port (
    input  wire logic        clk,
    input  wire logic        arst_n,
    tbx_mem_if.port          mif,
    output logic             mem_req,
    output logic [31:0]      mem_addr,
    output logic             mem_half,
    input  wire logic        mem_ack,
    input  wire logic [15:0] mem_rdata
);
    import tbx_pkg::*;
    logic busy_r;
    logic half_r;

    assign mif.req_ready = !busy_r;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_r   <= 1'b0;
            mem_req  <= 1'b0;
            mem_addr <= ADDR_RESET;
            mem_half <= 1'b0;
            half_r   <= 1'b0;
        end else if (mif.req_valid && !busy_r) begin
            busy_r   <= 1'b1;
            mem_req  <= 1'b1;
            mem_addr <= mif.req_addr;
            mem_half <= mif.req_half;
            half_r   <= mif.req_half;
        end else if (busy_r && mem_ack) begin
            busy_r   <= 1'b0;
            mem_req  <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mif.rsp_valid <= 1'b0;
            mif.rsp_data  <= ENTRY_RESET;
        end else begin
            mif.rsp_valid <= busy_r && mem_ack;
            // unsigned entry: no sign extension for either width
            mif.rsp_data  <= half_r ? mem_rdata : {8'h00, mem_rdata[7:0]};
        end
    end
endmodule : tbx_mem_port
`default_nettype wire

// >>> bench/tbx_mem_model.sv
// Purpose: table memory answering entry reads
// Assumes: one read at a time, answered after 0 to 3 idle cycles
// Notes:   data lines toggle outside the ack cycle so stale data never looks valid
`timescale 1ns/1ps
`default_nettype none
module tbx_mem_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        req,
    input  wire logic [31:0] addr,
    output logic             ack,
    output logic [15:0]      rdata
);
    logic [1:0] wait_r;
    logic       done_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {ack, rdata, wait_r, done_r} <= '0;
        end else begin
            ack <= 1'b0;
            rdata <= ~rdata;
            if (!req) begin
                done_r <= 1'b0;
                wait_r <= 2'($urandom % 4);
            end else if (!done_r && wait_r == 2'h0) begin
                // upper byte is noise for byte tables
                {ack, done_r} <= 2'b11;
                rdata <= addr[16:1] ^ 16'h3c5a;
            end else if (!done_r) begin
                wait_r <= wait_r - 2'h1;
            end
        end
    end
endmodule : tbx_mem_model
`default_nettype wire

// >>> bench/tbx_exec_chk.sv
// Purpose: port-level properties of the table branch block
// Assumes: fpu straps held steady around fp instructions
// Notes:   operands captured at each start seen while idle, refused ones included
`timescale 1ns/1ps
`default_nettype none
module tbx_exec_chk
    import tbx_pkg::*;
(
    input wire logic        CLK_IN, ARST_N_IN, START_IN, HALF_IN, IN_IT_BLOCK_IN, IT_LAST_IN,
    input wire logic        FP_INSN_IN, FPU_PRESENT_IN, FPU_ENABLE_IN, FP_ACCEPT_OUT,
    input wire logic        FP_REJECT_OUT, MEM_REQ_OUT, MEM_HALF_OUT, MEM_ACK_IN, BUSY_OUT,
    input wire logic        REDIRECT_OUT, FAULT_OUT,
    input wire logic [3:0]  BASE_SEL_IN, INDEX_SEL_IN,
    input wire logic [15:0] MEM_RDATA_IN,
    input wire logic [31:0] INSN_ADDR_IN, BASE_VAL_IN, INDEX_VAL_IN, MEM_ADDR_OUT, TARGET_OUT
);
    logic [31:0] cap_n, cap_a, exp_a;
    logic        cap_h, ok_w;
    logic [15:0] ent_w;
    assign exp_a = (BASE_SEL_IN == REG_PC ? INSN_ADDR_IN + INSN_LEN : BASE_VAL_IN)
                 + (HALF_IN ? INDEX_VAL_IN << 1 : INDEX_VAL_IN);
    assign ok_w = BASE_SEL_IN != REG_SP && INDEX_SEL_IN != REG_SP && INDEX_SEL_IN != REG_PC
                && (!IN_IT_BLOCK_IN || IT_LAST_IN);
    assign ent_w = cap_h ? MEM_RDATA_IN : {8'h00, MEM_RDATA_IN[7:0]};
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            {cap_n, cap_a, cap_h} <= '0;
        end else if (START_IN && !BUSY_OUT) begin
            {cap_n, cap_a, cap_h} <= {INSN_ADDR_IN + INSN_LEN, exp_a, HALF_IN};
        end
    end
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!ARST_N_IN);
    AST_START_REQ: assert property (START_IN && !BUSY_OUT && ok_w |-> ##2 MEM_REQ_OUT)
        else $error("no table read after start");
    AST_ADDR: assert property ($rose(MEM_REQ_OUT) |-> MEM_ADDR_OUT == cap_a
        && MEM_HALF_OUT == cap_h)
        else $error("wrong table entry address");
    AST_HOLD: assert property (MEM_REQ_OUT && !MEM_ACK_IN |=> MEM_REQ_OUT
        && $stable(MEM_ADDR_OUT))
        else $error("table read dropped early");
    AST_TARGET: assert property (MEM_ACK_IN && MEM_REQ_OUT |-> ##2 REDIRECT_OUT
        && TARGET_OUT == cap_n + {$past(ent_w, 2), 1'b0})
        else $error("wrong branch target");
    AST_FWD: assert property (REDIRECT_OUT |-> TARGET_OUT >= cap_n
        && TARGET_OUT[0] == cap_n[0])
        else $error("target not forward or misaligned");
    AST_BAD: assert property (START_IN && !BUSY_OUT && !ok_w |-> ##1 FAULT_OUT
        ##1 !MEM_REQ_OUT)
        else $error("illegal table branch not refused");
    AST_FP_ACC: assert property (FP_ACCEPT_OUT |-> FP_INSN_IN && $past(FPU_PRESENT_IN, 2)
        && $past(FPU_ENABLE_IN, 2))
        else $error("fp accepted without fpu");
    AST_FP_ONE: assert property ((FP_ACCEPT_OUT ^ FP_REJECT_OUT) == FP_INSN_IN)
        else $error("fp accept and reject disagree");
    cover property (REDIRECT_OUT && cap_h);
    cover property (REDIRECT_OUT && !cap_h);
    cover property (FAULT_OUT);
endmodule : tbx_exec_chk
bind tbx_exec tbx_exec_chk chk (.*);
`default_nettype wire

// >>> bench/testbench.sv
// Purpose: self-checking bench for the table branch block
// Assumes: memory partner answers after a short random wait
// Notes:   results checked in order against a queue of expected outputs
`timescale 1ns/1ps
`default_nettype none
`define CHK(o, e) begin compares++; if ((o) !== (e)) begin errors++; \
    $display("unexpected at %0t got %h expected %h", $time, o, e); end end
module testbench;
    import tbx_pkg::*;
    logic        clk, rst_n, start, half, in_it, it_last, fp, fpu_p, fpu_e;
    logic        fp_acc, fp_rej, req, mhalf, ack, busy, redir, fault;
    logic [3:0]  bsel, isel;
    logic [15:0] rdata;
    logic [31:0] insn, bval, ival, mem_addr, target;
    tbx_fault_t  code;
    logic [35:0] exp_q[$];
    logic [35:0] exp_v, got_v;
    int          errors = 0, compares = 0, cycles = 0;
    tbx_exec uut (.CLK_IN(clk), .ARST_N_IN(rst_n), .START_IN(start), .HALF_IN(half),
        .INSN_ADDR_IN(insn), .BASE_SEL_IN(bsel), .INDEX_SEL_IN(isel), .BASE_VAL_IN(bval),
        .INDEX_VAL_IN(ival), .IN_IT_BLOCK_IN(in_it), .IT_LAST_IN(it_last), .FP_INSN_IN(fp),
        .FPU_PRESENT_IN(fpu_p), .FPU_ENABLE_IN(fpu_e), .FP_ACCEPT_OUT(fp_acc),
        .FP_REJECT_OUT(fp_rej), .MEM_REQ_OUT(req), .MEM_ADDR_OUT(mem_addr), .MEM_HALF_OUT(mhalf),
        .MEM_ACK_IN(ack), .MEM_RDATA_IN(rdata), .BUSY_OUT(busy), .REDIRECT_OUT(redir),
        .TARGET_OUT(target), .FAULT_OUT(fault), .FAULT_CODE_OUT(code));
    tbx_mem_model mem (.clk(clk), .rst_n(rst_n), .req(req), .addr(mem_addr), .ack(ack),
        .rdata(rdata));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic print_verdict;
        if (errors == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : print_verdict
    always @(posedge clk) begin
        cycles++;
        if (redir || fault || fp) begin
            // pop once: the macro reads its expected value twice on a mismatch
            exp_v = (exp_q.size() != 0) ? exp_q.pop_front() : 36'h0;
            got_v = {redir, fault, fp_acc, fp_rej, redir ? target : fault ? 32'(code) : 32'h0};
            `CHK(got_v, exp_v)
        end
        if (cycles == 4000) begin
            errors++;
            print_verdict();
        end
    end
    task automatic branch(input logic h, input logic [3:0] bs, is, input logic it, il);
        logic [31:0] a, n;
        logic [15:0] d;
        logic        ok;
        logic        br;
        insn = 32'($urandom % 32'h10000) & 32'hfffe;
        bval = 32'($urandom % 32'h10000);
        ival = 32'($urandom % 256);
        n = insn + INSN_LEN;
        a = (bs == REG_PC ? n : bval) + (h ? ival << 1 : ival);
        d = a[16:1] ^ 16'h3c5a;
        br = bs == REG_SP || is == REG_SP || is == REG_PC;
        ok = !br && !(it && !il);
        // operand faults outrank the if-then placement fault
        if (!ok) exp_q.push_back({4'b0100, 32'(br ? TBX_BAD_REG : TBX_BAD_IT)});
        else exp_q.push_back({4'b1000, n + {15'h0, h ? d : {8'h00, d[7:0]}, 1'b0}});
        {half, bsel, isel, in_it, it_last, start} = {h, bs, is, it, il, 1'b1};
        // holding start into the busy cycle checks that it is ignored
        repeat (ok ? 2 : 1) @(posedge clk);
        #2 start = 1'b0;
        repeat (2) @(posedge clk);
        #2 while (busy) begin
            @(posedge clk);
            #2;
        end
    endtask : branch
    initial begin
        void'($urandom(32'h3950f0fe));
        {rst_n, start, half, in_it, it_last, fp, fpu_p, fpu_e, bsel, isel} = '0;
        {insn, bval, ival} = '0;
        repeat (6) @(posedge clk);
        #2 rst_n = 1'b1;
        for (int i = 0; i < 24; i++)
            branch(i[0], i % 3 == 0 ? REG_PC : 4'($urandom % 13), 4'($urandom % 13), i % 4 == 1, 1'b1);
        branch(1'b0, REG_SP, 4'h1, 1'b0, 1'b1);
        branch(1'b1, 4'h2, REG_SP, 1'b0, 1'b1);
        branch(1'b0, 4'h2, REG_PC, 1'b0, 1'b1);
        branch(1'b1, 4'h3, 4'h4, 1'b1, 1'b0);
        branch(1'b0, REG_SP, 4'h1, 1'b1, 1'b0);
        branch(1'b1, REG_PC, 4'h0, 1'b0, 1'b1);
        for (int k = 0; k < 4; k++) begin
            {fpu_p, fpu_e} = 2'(k);
            repeat (3) @(posedge clk);
            #2 fp = 1'b1;
            exp_q.push_back({2'b00, fpu_p & fpu_e, ~(fpu_p & fpu_e), 32'h0});
            if (!(fpu_p && fpu_e)) exp_q.push_back({4'b0100, 32'(TBX_NO_FPU)});
            @(posedge clk);
            #2 fp = 1'b0;
        end
        repeat (4) @(posedge clk);
        if (exp_q.size() != 0) errors++;
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
